/* File: acc_pkg.sv */
package acc_pkg;

  // ----------------------------------------------------------------------
  // register offsets (i/o space)
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFS_RESULT_LOW  = 6'h04;
  localparam logic [5:0] OFS_RESULT_HIGH = 6'h05;
  localparam logic [5:0] OFS_CTRL_STATUS = 6'h06;
  localparam logic [5:0] OFS_INPUT_SEL   = 6'h07;

  // ----------------------------------------------------------------------
  // control/status and input select field positions
  // ----------------------------------------------------------------------
  localparam int BIT_ENABLE     = 7;
  localparam int BIT_START      = 6;
  localparam int BIT_FREE_RUN   = 5;
  localparam int BIT_FLAG       = 4;
  localparam int BIT_IRQ_ENABLE = 3;
  localparam int BIT_LEFT_ADJ   = 5;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------------
  // conversion timing in converter clock cycles
  // ----------------------------------------------------------------------
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'h19;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0D;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] reference_select;
    logic [4:0] channel_select;
  } acc_sel_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } acc_io_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_IDLE,
    ST_CONVERT
  } acc_state_t;

endpackage

/* File: acc_prescaler.sv */
`timescale 1ns/1ps
module acc_prescaler (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] prescaler_select_i,
  // converter clock enable
  output logic            tick_o
);

  logic [6:0] count;
  logic [6:0] limit;

  // codes 0 and 1 both divide by two
  always_comb begin
    if (prescaler_select_i == 3'h0) begin
      limit = 7'h01;
    end else begin
      limit = 7'((8'h01 << prescaler_select_i) - 8'h01);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !run_i) begin
      count  <= 7'h00;
      tick_o <= 1'b0;
    end else if (count >= limit) begin
      count  <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 7'h01;
      tick_o <= 1'b0;
    end
  end

endmodule

/* File: acc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - enable bit powers converter; clearing it aborts a running conversion
// - writing start begins conversion; free-running needs only first start
// - first conversion after enable takes 25 converter clocks, later 13
// - start reads one while converting, zero after; writing zero ignored
// - free-running select makes conversions continuous; clearing it stops them
// - completion flag sets when conversion ends, even while result held frozen
// - flag clears on interrupt vector acknowledge or writing one to it
// - irq raised while flag, local enable and global enable all set
// - converter clock is system clock divided per three-bit prescaler
// - differential input result presented as two's complement
// - after low byte read, result frozen until high byte read
// - right adjust: bits 7:0 low byte, 9:8 in high bits 1:0
// - left adjust: bits 9:2 high byte, 1:0 in low bits 7:6
// - result low at 0x04, high at 0x05, read-only, reset zero
// - reference and channel changes take effect after current conversion
// - left adjust change alters result presentation immediately
module acc_top #(
  parameter int RESULT_WIDTH = 10
) (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  // i/o register port
  input  wire acc_pkg::acc_io_t        io_i,
  output logic [7:0]                   io_rdata_o,
  // processor interrupt side
  input  wire logic                    global_irq_enable_i,
  input  wire logic                    irq_ack_i,
  output logic                         irq_o,
  // analog core
  input  wire logic [RESULT_WIDTH-1:0] sample_i,
  output acc_pkg::acc_sel_t            core_sel_o,
  output logic                         core_power_o,
  output logic                         core_sample_o
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  acc_pkg::acc_state_t     state;
  logic                    converter_enable;
  logic                    free_running_select;
  logic                    completion_flag;
  logic                    completion_irq_enable;
  logic [2:0]              prescaler_select;
  logic                    left_adjust;
  acc_pkg::acc_sel_t       input_sel;
  logic [RESULT_WIDTH-1:0] result;
  logic                    frozen;
  logic                    pending_valid;
  logic [RESULT_WIDTH-1:0] pending;
  logic                    first_conv;
  logic [4:0]              cycles;
  logic                    tick;
  logic                    wr_ctrl;
  logic                    start_req;
  logic                    conv_done;
  logic [7:0]              ctrl_byte;
  logic [7:0]              low_byte;
  logic [7:0]              high_byte;

  assign wr_ctrl   = io_i.we && io_i.addr == acc_pkg::OFS_CTRL_STATUS;
  assign start_req = wr_ctrl && io_i.wdata[acc_pkg::BIT_START]
                     && io_i.wdata[acc_pkg::BIT_ENABLE];
  assign conv_done = state == acc_pkg::ST_CONVERT && tick
                     && cycles == 5'h01;

  acc_prescaler u_prescaler (
    .ref_clk_i          (ref_clk_i),
    .nrst_i             (nrst_i),
    .run_i              (converter_enable),
    .prescaler_select_i (prescaler_select),
    .tick_o             (tick)
  );

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      converter_enable      <= 1'b0;
      free_running_select   <= 1'b0;
      completion_irq_enable <= 1'b0;
      prescaler_select      <= 3'h0;
    end else if (wr_ctrl) begin
      converter_enable      <= io_i.wdata[acc_pkg::BIT_ENABLE];
      free_running_select   <= io_i.wdata[acc_pkg::BIT_FREE_RUN];
      completion_irq_enable <= io_i.wdata[acc_pkg::BIT_IRQ_ENABLE];
      prescaler_select      <= io_i.wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      left_adjust <= 1'b0;
      input_sel   <= '0;
    end else if (io_i.we && io_i.addr == acc_pkg::OFS_INPUT_SEL) begin
      left_adjust <= io_i.wdata[acc_pkg::BIT_LEFT_ADJ];
      input_sel   <= {io_i.wdata[7:6], io_i.wdata[4:0]};
    end
  end

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state      <= acc_pkg::ST_OFF;
      first_conv <= 1'b1;
      cycles     <= 5'h00;
      core_sel_o <= '0;
    end else if (wr_ctrl && !io_i.wdata[acc_pkg::BIT_ENABLE]) begin
      state      <= acc_pkg::ST_OFF;
      first_conv <= 1'b1;
    end else begin
      case (state)
        acc_pkg::ST_OFF: begin
          if (start_req) begin
            state      <= acc_pkg::ST_CONVERT;
            cycles     <= acc_pkg::FIRST_CONV_CYCLES;
            core_sel_o <= input_sel;
          end else if (wr_ctrl) begin
            state <= acc_pkg::ST_IDLE;
          end
        end
        acc_pkg::ST_IDLE: begin
          if (start_req) begin
            state      <= acc_pkg::ST_CONVERT;
            cycles     <= first_conv ? acc_pkg::FIRST_CONV_CYCLES
                                     : acc_pkg::NORMAL_CONV_CYCLES;
            core_sel_o <= input_sel;
          end
        end
        acc_pkg::ST_CONVERT: begin
          if (conv_done) begin
            first_conv <= 1'b0;
            core_sel_o <= input_sel;
            if (free_running_select) begin
              cycles <= acc_pkg::NORMAL_CONV_CYCLES;
            end else begin
              state <= acc_pkg::ST_IDLE;
            end
          end else if (tick) begin
            cycles <= cycles - 5'h01;
          end
        end
        default: begin
          state <= acc_pkg::ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // result capture with read interlock
  // ----------------------------------------------------------------------
  // a result finishing while frozen waits in pending rather than being lost
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      result        <= '0;
      frozen        <= 1'b0;
      pending_valid <= 1'b0;
      pending       <= '0;
    end else begin
      if (io_i.re && io_i.addr == acc_pkg::OFS_RESULT_LOW) begin
        frozen <= 1'b1;
      end else if (io_i.re && io_i.addr == acc_pkg::OFS_RESULT_HIGH) begin
        frozen <= 1'b0;
      end
      if (conv_done && frozen) begin
        pending       <= sample_i;
        pending_valid <= 1'b1;
      end else if (conv_done) begin
        result <= sample_i;                    // core gives two's compl.
        // a fresh result outranks an older one still waiting in pending
        pending_valid <= 1'b0;
      end else if (pending_valid && !frozen) begin
        result        <= pending;
        pending_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // completion flag, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      completion_flag <= 1'b0;
    end else if (conv_done) begin
      completion_flag <= 1'b1;
    end else if (irq_ack_i
                 || (wr_ctrl && io_i.wdata[acc_pkg::BIT_FLAG])) begin
      completion_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read path and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_byte = {converter_enable, state == acc_pkg::ST_CONVERT,
                 free_running_select, completion_flag,
                 completion_irq_enable, prescaler_select};
    if (left_adjust) begin
      high_byte = result[9:2];
      low_byte  = {result[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, result[9:8]};
      low_byte  = result[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      io_rdata_o    <= acc_pkg::RESET_BYTE;
      irq_o         <= 1'b0;
      core_power_o  <= 1'b0;
      core_sample_o <= 1'b0;
    end else begin
      irq_o         <= completion_flag && completion_irq_enable
                       && global_irq_enable_i;
      core_power_o  <= converter_enable;
      core_sample_o <= conv_done;
      case (io_i.addr)
        acc_pkg::OFS_RESULT_LOW:  io_rdata_o <= low_byte;
        acc_pkg::OFS_RESULT_HIGH: io_rdata_o <= high_byte;
        acc_pkg::OFS_CTRL_STATUS: io_rdata_o <= ctrl_byte;
        acc_pkg::OFS_INPUT_SEL: begin
          io_rdata_o <= {input_sel.reference_select, left_adjust,
                         input_sel.channel_select};
        end
        default:                  io_rdata_o <= acc_pkg::RESET_BYTE;
      endcase
    end
  end

endmodule

/* File: acc_sva.sv */
`timescale 1ns/1ps
module acc_sva #(
  parameter int RESULT_WIDTH = 10
) (
  // clock, reset, register port
  input wire logic                    ref_clk_i,
  input wire logic                    nrst_i,
  input wire acc_pkg::acc_io_t        io_i,
  input wire logic [7:0]              io_rdata_o,
  // interrupt and analog core
  input wire logic                    global_irq_enable_i,
  input wire logic                    irq_ack_i,
  input wire logic                    irq_o,
  input wire logic [RESULT_WIDTH-1:0] sample_i,
  input wire acc_pkg::acc_sel_t       core_sel_o,
  input wire logic                    core_power_o,
  input wire logic                    core_sample_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] gap;
  logic       ctl_wr;
  assign ctl_wr = io_i.we && io_i.addr == acc_pkg::OFS_CTRL_STATUS;
  // clocks since power-up or last capture; 13 ticks at /2 is the floor
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !core_power_o || core_sample_o) begin
      gap <= 8'h00;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  chk_irq_gate:
    assert property (irq_o |-> $past(global_irq_enable_i))
    else $error("irq ungated");
  chk_power_on:
    assert property (ctl_wr && io_i.wdata[7] |-> ##[1:2] core_power_o)
    else $error("core not powered");
  chk_power_off:
    assert property (ctl_wr && !io_i.wdata[7] |-> ##[1:2] !core_power_o)
    else $error("core still powered");
  chk_capture_gap:
    assert property (core_sample_o |-> gap >= 8'h18)
    else $error("capture too soon");
  chk_sample_pulse:
    assert property (core_sample_o |=> !core_sample_o)
    else $error("long capture");
  // set wins: a completion in the clearing cycle legally keeps irq up
  chk_ack_clears:
    assert property (irq_ack_i |-> ##2 (!irq_o || $past(core_sample_o)))
    else $error("ack kept irq");
  chk_flag_wr_clear:
    assert property (ctl_wr && io_i.wdata[4]
                     |-> ##2 (!irq_o || $past(core_sample_o)))
    else $error("flag kept");
  chk_unmapped_read:
    assert property ((io_i.addr < 6'h04 || io_i.addr > 6'h07)
                     |=> io_rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  chk_reset_quiet:
    assert property ($rose(nrst_i)
                     |-> io_rdata_o == 8'h00 && !irq_o && !core_power_o)
    else $error("outputs not cleared");
  cover property (core_sample_o);
  cover property (irq_o);
  cover property (irq_ack_i);
endmodule

bind acc_top acc_sva #(.RESULT_WIDTH(RESULT_WIDTH)) acc_sva_i (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .io_i(io_i),
  .io_rdata_o(io_rdata_o), .global_irq_enable_i(global_irq_enable_i),
  .irq_ack_i(irq_ack_i), .irq_o(irq_o), .sample_i(sample_i),
  .core_sel_o(core_sel_o), .core_power_o(core_power_o),
  .core_sample_o(core_sample_o));

/* File: acc_core_model.sv */
`timescale 1ns/1ps
module acc_core_model (
  // clock
  input  wire logic              ref_clk_i,
  // control from the block
  input  wire logic              power_i,
  input  wire acc_pkg::acc_sel_t sel_i,
  // result
  output logic [9:0]             sample_o
);
  logic [9:0] junk;
  initial junk = 10'h155;
  // unpowered core shows a pattern that changes every cycle
  always @(posedge ref_clk_i) junk <= ~junk;
  assign sample_o = power_i ? {~sel_i.channel_select, 5'h15} : junk;
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic              ref_clk_i;
  logic              nrst_i;
  acc_pkg::acc_io_t  io;
  logic [7:0]        rdata;
  logic              gie;
  logic              ack;
  logic              irq;
  logic [9:0]        smp;
  acc_pkg::acc_sel_t sel;
  logic              pwr;
  logic              spl;
  logic [7:0]        v;
  int                n;
  int                cyc;
  int                failures;
  int                n_compared;
  acc_top acc_top_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .io_i(io), .io_rdata_o(rdata),
    .global_irq_enable_i(gie), .irq_ack_i(ack), .irq_o(irq),
    .sample_i(smp), .core_sel_o(sel), .core_power_o(pwr),
    .core_sample_o(spl));
  acc_core_model acc_core_model_i (
    .ref_clk_i(ref_clk_i), .power_i(pwr), .sel_i(sel), .sample_o(smp));
  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk_i) io = {1'b1, 1'b0, a, d};
    @(negedge ref_clk_i) io.we = 1'b0;
  endtask
  // data is registered, so it is taken one cycle after the address
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge ref_clk_i) io = {1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk_i) io.re = 1'b0;
    d = rdata;
  endtask
  task automatic conv(input logic [7:0] ctl);
    wr(acc_pkg::OFS_CTRL_STATUS, ctl);
    n = 0;
    do begin
      rd(acc_pkg::OFS_CTRL_STATUS, v);
      n += 2;
    end while (v[acc_pkg::BIT_START] === 1'b1 && n < 600);
  endtask
  task automatic close_out;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    wr(6'h04, 8'hFF);
    wr(6'h05, 8'hFF);
    for (int i = 4; i < 8; i++) begin
      rd(6'(i), v);
      cmp(v, 8'h00);
    end
    rd(6'h3F, v);
    cmp(v, 8'h00);
  endtask
  task automatic t_single;
    wr(acc_pkg::OFS_INPUT_SEL, 8'h03);
    conv(8'hC8);
    cmp(8'(n >= 48 && n <= 62), 8'h01);
    cmp(v, 8'h98);
    cmp({7'h00, irq}, 8'h01);
    gie = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    cmp({7'h00, irq}, 8'h00);
    gie = 1'b1;
    rd(6'h04, v);
    cmp(v, 8'h95);
    rd(6'h05, v);
    cmp(v, 8'h03);
    wr(acc_pkg::OFS_INPUT_SEL, 8'h23);
    rd(6'h04, v);
    cmp(v, 8'h40);
    rd(6'h05, v);
    cmp(v, 8'hE5);
  endtask
  task automatic t_clear;
    // whole-byte write, never read-modify-write, so the flag clear is meant
    wr(acc_pkg::OFS_CTRL_STATUS, 8'h98);
    rd(acc_pkg::OFS_CTRL_STATUS, v);
    cmp(v, 8'h88);
    cmp({7'h00, irq}, 8'h00);
    conv(8'hCB);
    // 13 ticks of /8; the free-running divider puts the first tick 1 to 8
    // clocks after the start, and polling sees the end on an even count
    cmp(8'(n >= 98 && n <= 106), 8'h01);
    cmp(v, 8'h9B);
    @(negedge ref_clk_i) ack = 1'b1;
    @(negedge ref_clk_i) ack = 1'b0;
    rd(acc_pkg::OFS_CTRL_STATUS, v);
    cmp(v, 8'h8B);
  endtask
  task automatic t_free;
    wr(acc_pkg::OFS_INPUT_SEL, 8'h05);
    wr(acc_pkg::OFS_CTRL_STATUS, 8'hE0);
    repeat (80) @(negedge ref_clk_i);
    rd(acc_pkg::OFS_CTRL_STATUS, v);
    cmp(v, 8'hF0);
    rd(6'h04, v);
    cmp(v, 8'h55);
    wr(acc_pkg::OFS_INPUT_SEL, 8'h09);
    repeat (120) @(negedge ref_clk_i);
    rd(6'h05, v);
    cmp(v, 8'h03);
    repeat (80) @(negedge ref_clk_i);
    rd(6'h04, v);
    cmp(v, 8'hD5);
    rd(6'h05, v);
    cmp(v, 8'h02);
    wr(acc_pkg::OFS_CTRL_STATUS, 8'h80);
    repeat (60) @(negedge ref_clk_i);
    rd(acc_pkg::OFS_CTRL_STATUS, v);
    cmp(v, 8'h90);
  endtask
  task automatic t_abort;
    wr(acc_pkg::OFS_CTRL_STATUS, 8'h10);
    wr(acc_pkg::OFS_CTRL_STATUS, 8'hC0);
    repeat (10) @(negedge ref_clk_i);
    wr(acc_pkg::OFS_CTRL_STATUS, 8'h00);
    repeat (60) @(negedge ref_clk_i);
    rd(acc_pkg::OFS_CTRL_STATUS, v);
    cmp(v, 8'h00);
    cmp({7'h00, pwr}, 8'h00);
  endtask
  // ----------------------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    io = '0;
    gie = 1'b1;
    ack = 1'b0;
    nrst_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_regs();
    t_single();
    t_clear();
    t_free();
    t_abort();
    close_out();
  end
endmodule
